// >>> pmmu_probe_pkg.sv
// constants, field positions and types for the probe / condition-set unit
// assumes a 32-bit bus slave at 100 MHz; all registers one aligned word
package pmmu_probe_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_status = 8'h04;
  localparam logic [7:0] off_cmd = 8'h08;
  localparam logic [7:0] off_operand = 8'h0c;
  localparam logic [7:0] off_laddr = 8'h10;
  localparam logic [7:0] off_result = 8'h14;
  localparam logic [7:0] off_daddr = 8'h18;
  localparam logic [2:0] hsize_word = 3'h2;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int ctl_enable = 0;
  localparam int ctl_root_lo = 1;
  localparam int ctl_cal_lo = 4;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [15:0] status_reset = 16'h0000;

  // ----------------------------------------------------------------
  // status register bit positions
  // ----------------------------------------------------------------
  localparam int sb_b = 15;
  localparam int sb_l = 14;
  localparam int sb_s = 13;
  localparam int sb_a = 11;
  localparam int sb_w = 10;
  localparam int sb_i = 9;
  localparam int sb_m = 7;
  localparam int sb_g = 5;
  localparam int sb_c = 4;

  // ----------------------------------------------------------------
  // command word fields, result fields, codes
  // ----------------------------------------------------------------
  localparam int cmd_probe = 8;
  localparam int cmd_super = 9;
  localparam int res_done = 8;
  localparam int res_busy = 9;
  localparam int res_illop = 10;
  localparam int res_priv = 11;
  localparam int res_fline = 12;
  localparam int res_ea_rej = 13;
  localparam int res_ret = 14;
  localparam int res_cbad = 21;
  localparam logic [7:0] vec_illegal = 8'h39;
  localparam logic [1:0] dt_invalid = 2'h0;
  localparam logic [1:0] dt_page = 2'h1;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_cache = 3'b010,
    st_walk = 3'b100
  } state_t;

endpackage

// >>> unit_condition_eval.sv
// selects one status flag by a six-bit condition code
// assumes status comes from the probe unit's own register
`timescale 1ns/1ps
module unit_condition_eval import pmmu_probe_pkg::*; (
  // status flags and selector
  input wire logic [15:0] status,
  input wire logic [5:0] cond,
  // answer
  output logic truth,
  output logic bad
);

  logic [7:0] flags;

  // ------------------------------------------------------------
  // flag table, even code tests set, odd code tests clear
  // ------------------------------------------------------------
  assign flags = {status[sb_c], status[sb_g], status[sb_i], status[sb_w],
                  status[sb_a], status[sb_s], status[sb_l], status[sb_b]};
  assign bad = (cond[5:4] != 2'h0); // R2
  assign truth = !bad && (flags[cond[3:1]] ^ cond[0]); // R2

endmodule

// >>> walk_flag_merge.sv
// folds one fetched descriptor into the accumulated status flags
// assumes descriptor fields are valid only while the fetch is acknowledged
`timescale 1ns/1ps
module walk_flag_merge import pmmu_probe_pkg::*; (
  // accumulated flags and probe parameters
  input wire logic [15:0] acc,
  input wire logic rd_probe,
  input wire logic fc_super,
  input wire logic [2:0] cal,
  // descriptor just fetched
  input wire logic bus_fault_marker,
  input wire logic is_long,
  input wire logic limit,
  input wire logic super_only,
  input wire logic [2:0] read_access_level_field,
  input wire logic [2:0] write_access_level_field,
  input wire logic wp,
  input wire logic is_page,
  input wire logic dm,
  input wire logic dg,
  input wire logic shared,
  // merged flags
  output logic [15:0] merged
);

  logic ok;
  logic rd_deny;
  logic wr_deny;

  // ------------------------------------------------------------
  // access level compare, larger level means less privilege
  // ------------------------------------------------------------
  assign ok = !bus_fault_marker;
  assign rd_deny = ok && is_long && (cal > read_access_level_field);
  assign wr_deny = ok && is_long && (cal > write_access_level_field);

  // flags accumulate except sb_m and sb_g, which a page descriptor overwrites
  always_comb begin
    merged = acc;
    merged[sb_b] = acc[sb_b] | bus_fault_marker; // R15
    merged[sb_l] = acc[sb_l] | (ok && is_long && limit); // R16
    merged[sb_s] = acc[sb_s] | (ok && is_long && super_only && !fc_super); // R17
    merged[sb_a] = acc[sb_a] | rd_deny | (!rd_probe && wr_deny); // R9 R18
    merged[sb_w] = acc[sb_w] | (ok && wp) | wr_deny; // R19
    merged[sb_c] = acc[sb_c] | (ok && shared); // R20
    if (ok && is_page) begin
      merged[sb_m] = dm; // R21
      merged[sb_g] = dg; // R21
    end
  end

endmodule

// >>> mmu_probe_and_condition_set.sv
// paged unit: condition-set byte and address probe, AHB-Lite register slave
// assumes translation cache and descriptor fetch logic sit on the same clock
//
// Behaviour
// [R1] condition-set writes all ones if condition true, all zeros if false
// [R2] six-bit selector: even code tests flag set, next odd code tests clear
// [R3] condition-set accepts only data alterable modes; others rejected
// [R4] probe only in supervisor state, else privilege trap; fills status
// [R5] translation disabled: probe raises illegal-operation, vector 39
// [R6] function code from immediate, data register, source or destination fc
// [R7] fc field: 1DDDD immediate, 01RRR data reg, 00000 source, 00001 dest
// [R8] level zero searches cache only; one to seven bound the walk
// [R9] read/write bit picks which access levels set the access flag
// [R10] probe walk never alters used or modified descriptor bits
// [R11] return address of last clean descriptor; zero for page root pointer
// [R12] walk stops at level or invalid, limit, bus error; flags accumulate
// [R13] return field: leading zero none, leading one names address register
// [R14] level zero with nonzero return field gives F-line exception
// [R15] bus-error flag from descriptor fetch or faulty cache entry
// [R16] limit flag when a long descriptor limit is exceeded
// [R17] supervisor flag when supervisor-only and fc bit 2 clear
// [R18] access flag on read level deny, or either level on write probe
// [R19] write-protect flag on any wp bit or write level deny
// [R20] invalid flag without valid translation; shared flag when shared
// [R21] modified and gate flags from cache hit or reached page descriptor
// [R22] level count holds levels searched; zero for level zero or page root
// [R23] condition-set leaves status alone and reads current flags
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module mmu_probe_and_condition_set import pmmu_probe_pkg::*; (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // translation cache lookup
  output logic cache_req,
  output logic [3:0] cache_fc,
  output logic [31:0] cache_laddr,
  input wire logic cache_ack,
  input wire logic cache_hit,
  input wire logic cache_bus_fault_marker,
  input wire logic cache_wp,
  input wire logic cache_m,
  input wire logic cache_g,
  input wire logic cache_shared,
  // descriptor fetch, read only
  output logic walk_req,
  output logic [2:0] walk_level,
  input wire logic desc_ack,
  input wire logic desc_bus_fault_marker,
  input wire logic [1:0] desc_type,
  input wire logic desc_long,
  input wire logic desc_limit,
  input wire logic desc_super,
  input wire logic [2:0] desc_ral,
  input wire logic [2:0] desc_wal,
  input wire logic desc_wp,
  input wire logic desc_m,
  input wire logic desc_g,
  input wire logic desc_shared,
  input wire logic [31:0] desc_addr
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic addr_ph;
  logic bwr_r, bwr_nxt;
  logic [7:0] baddr_r, baddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [31:0] rd_mux;
  state_t state_r, state_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] operand_r, operand_nxt;
  logic [31:0] laddr_r, laddr_nxt;
  logic [31:0] result_r, result_nxt;
  logic [31:0] daddr_r, daddr_nxt;
  logic [3:0] fc_r, fc_nxt;
  logic [2:0] level_r, level_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic rw_r, rw_nxt;
  logic wr_cmd;
  logic cs_go;
  logic pr_go;
  logic [15:0] ext;
  logic [5:0] ea;
  logic ea_ok;
  logic fc_ok;
  logic [3:0] fc_sel;
  logic cond_true;
  logic cond_bad;
  logic [15:0] merged;
  logic [2:0] cnt1;
  logic stop;

  // ------------------------------------------------------------
  // bus address phase capture, zero wait while ce high, always OKAY
  // ------------------------------------------------------------
  assign addr_ph = hsel && htrans[1] && hready && (hsize == hsize_word);
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // read data chosen in address phase, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0;
    if (haddr[31:8] == 24'h0) begin
      unique case (haddr[7:0])
        off_ctrl: rd_mux = {24'h0, ctrl_r};
        off_status: rd_mux = {16'h0, status_r};
        off_operand: rd_mux = {16'h0, operand_r};
        off_laddr: rd_mux = laddr_r;
        off_result: rd_mux = {result_r[31:10], state_r != st_idle, result_r[8:0]};
        off_daddr: rd_mux = daddr_r;
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // next bus state
  always_comb begin
    bwr_nxt = addr_ph && hwrite;
    baddr_nxt = addr_ph ? haddr[7:0] : baddr_r;
    hrdata_nxt = (addr_ph && !hwrite) ? rd_mux : hrdata_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bwr_r <= 1'b0;
      baddr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else if (ce) begin
      bwr_r <= bwr_nxt;
      baddr_r <= baddr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // command decode in the write data phase
  // ------------------------------------------------------------
  assign wr_cmd = bwr_r && (baddr_r == off_cmd);
  assign ext = hwdata[31:16];
  assign ea = hwdata[5:0];
  assign cs_go = wr_cmd && !hwdata[cmd_probe] && (state_r == st_idle);
  assign pr_go = wr_cmd && hwdata[cmd_probe] && (state_r == st_idle);

  // data alterable destinations only
  always_comb begin
    unique case (ea[5:3])
      3'h1: ea_ok = 1'b0; // R3
      3'h7: ea_ok = (ea[2:1] == 2'h0); // R3
      default: ea_ok = 1'b1; // R3
    endcase
  end

  // function code source
  always_comb begin
    fc_ok = 1'b1;
    fc_sel = 4'h0;
    if (ext[4]) begin
      fc_sel = ext[3:0]; // R7
    end else if (ext[3]) begin
      fc_sel = operand_r[3:0]; // R6
    end else if (ext[2:0] == 3'h0) begin
      fc_sel = {1'b0, operand_r[6:4]}; // R6
    end else if (ext[2:0] == 3'h1) begin
      fc_sel = {1'b0, operand_r[10:8]}; // R6
    end else begin
      fc_ok = 1'b0;
    end
  end

  unit_condition_eval u_cond (
    .status(status_r),
    .cond(ext[5:0]),
    .truth(cond_true),
    .bad(cond_bad)
  );

  walk_flag_merge u_merge (
    .acc(status_r),
    .rd_probe(rw_r),
    .fc_super(fc_r[2]),
    .cal(ctrl_r[ctl_cal_lo +: 3]),
    .bus_fault_marker(desc_bus_fault_marker),
    .is_long(desc_long),
    .limit(desc_limit),
    .super_only(desc_super),
    .read_access_level_field(desc_ral),
    .write_access_level_field(desc_wal),
    .wp(desc_wp),
    .is_page(desc_type == dt_page),
    .dm(desc_m),
    .dg(desc_g),
    .shared(desc_shared),
    .merged(merged)
  );

  // ------------------------------------------------------------
  // probe engine and register file
  // ------------------------------------------------------------
  assign cache_req = (state_r == st_cache);
  assign walk_req = (state_r == st_walk); // R10
  assign cache_fc = fc_r;
  assign cache_laddr = laddr_r;
  assign walk_level = cnt_r;
  assign cnt1 = cnt_r + 3'h1;
  assign stop = desc_bus_fault_marker || (desc_type == dt_invalid) || desc_limit
                || (desc_type == dt_page) || (cnt1 == level_r); // R12

  // next values of engine and software registers
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    status_nxt = status_r;
    operand_nxt = operand_r;
    laddr_nxt = laddr_r;
    result_nxt = result_r;
    daddr_nxt = daddr_r;
    fc_nxt = fc_r;
    level_nxt = level_r;
    cnt_nxt = cnt_r;
    rw_nxt = rw_r;
    if (bwr_r && baddr_r == off_ctrl) ctrl_nxt = hwdata[7:0];
    if (bwr_r && baddr_r == off_status) status_nxt = hwdata[15:0];
    if (bwr_r && baddr_r == off_operand) operand_nxt = hwdata[15:0];
    if (bwr_r && baddr_r == off_laddr) laddr_nxt = hwdata;
    if (cs_go) begin
      result_nxt = 32'h0;
      result_nxt[res_done] = 1'b1;
      result_nxt[res_cbad] = cond_bad;
      if (!ea_ok) begin
        result_nxt[res_ea_rej] = 1'b1; // R3
      end else begin
        result_nxt[7:0] = cond_true ? 8'hff : 8'h00; // R1 R23
      end
    end
    if (pr_go) begin
      result_nxt = 32'h0;
      result_nxt[res_ret] = ext[8]; // R13
      result_nxt[17:15] = ext[7:5]; // R13
      result_nxt[20:18] = ext[2:0];
      fc_nxt = fc_sel;
      level_nxt = ext[12:10];
      rw_nxt = ext[9];
      cnt_nxt = 3'h0;
      if (!hwdata[cmd_super]) begin
        result_nxt[res_priv] = 1'b1; // R4
        result_nxt[res_done] = 1'b1;
      end else if (!ctrl_r[ctl_enable]) begin
        result_nxt[res_illop] = 1'b1; // R5
        result_nxt[31:24] = vec_illegal; // R5
        result_nxt[res_done] = 1'b1;
      end else if (!fc_ok || (ext[12:10] == 3'h0 && ext[8:5] != 4'h0)) begin
        result_nxt[res_fline] = 1'b1; // R14
        result_nxt[res_done] = 1'b1;
      end else begin
        status_nxt = status_reset; // R4
        daddr_nxt = 32'h0;
        if (ext[12:10] == 3'h0) begin
          state_nxt = st_cache; // R8
        end else if (ctrl_r[ctl_root_lo +: 2] == dt_page) begin
          result_nxt[res_done] = 1'b1; // R11 R22
        end else begin
          state_nxt = st_walk; // R8
        end
      end
    end
    unique case (state_r)
      st_cache: begin
        if (cache_ack) begin
          status_nxt = status_reset; // R22
          status_nxt[sb_b] = cache_hit && cache_bus_fault_marker; // R15
          status_nxt[sb_w] = cache_hit && cache_wp;
          status_nxt[sb_m] = cache_hit && cache_m; // R21
          status_nxt[sb_g] = cache_hit && cache_g; // R21
          status_nxt[sb_c] = cache_hit && cache_shared; // R20
          status_nxt[sb_i] = !cache_hit || cache_bus_fault_marker; // R20
          result_nxt[res_done] = 1'b1;
          state_nxt = st_idle;
        end
      end
      st_walk: begin
        if (desc_ack) begin
          status_nxt = merged; // R12
          status_nxt[2:0] = cnt1; // R22
          cnt_nxt = cnt1;
          if (!desc_bus_fault_marker) daddr_nxt = desc_addr; // R11
          if (stop) begin
            status_nxt[sb_i] = (desc_type != dt_page) || desc_bus_fault_marker || desc_limit; // R20
            result_nxt[res_done] = 1'b1;
            state_nxt = st_idle;
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= st_idle;
      ctrl_r <= ctrl_reset;
      status_r <= status_reset;
      operand_r <= 16'h0;
      laddr_r <= 32'h0;
      result_r <= 32'h0;
      daddr_r <= 32'h0;
      fc_r <= 4'h0;
      level_r <= 3'h0;
      cnt_r <= 3'h0;
      rw_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      operand_r <= operand_nxt;
      laddr_r <= laddr_nxt;
      result_r <= result_nxt;
      daddr_r <= daddr_nxt;
      fc_r <= fc_nxt;
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
      rw_r <= rw_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  cond_byte_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (ce && cs_go && ea_ok) |=> result_r[7:0] == ($past(cond_true) ? 8'hff : 8'h00))
    else $error("condition byte wrong");
  status_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R23
    (ce && cs_go && !(bwr_r && baddr_r == off_status)) |=> $stable(status_r))
    else $error("condition-set changed status");
  illegal_vec_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    (ce && pr_go && hwdata[cmd_super] && !ctrl_r[ctl_enable])
    |=> result_r[31:24] == vec_illegal && state_r == st_idle)
    else $error("disabled probe not refused");
  priv_trap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (ce && pr_go && !hwdata[cmd_super]) |=> result_r[res_priv] && !walk_req && !cache_req)
    else $error("user probe not trapped");
  fline_lvl0_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    (ce && pr_go && hwdata[cmd_super] && ctrl_r[ctl_enable] && ext[12:10] == 3'h0
     && ext[8:5] != 4'h0) |=> result_r[res_fline] && state_r == st_idle)
    else $error("bad return field accepted");
  walk_bound_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    walk_req |-> cnt_r < level_r)
    else $error("walk beyond level");
  n_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // R22
    (ce && cache_req && cache_ack) |=> status_r[2:0] == 3'h0 && !cache_req)
    else $error("cache probe level count");
  walk_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    (walk_req && !(ce && desc_ack)) |=> walk_req && $stable(walk_level))
    else $error("walk request dropped");

endmodule

// >>> probe_far_side.sv
// far-side model: translation cache lookup and descriptor fetch for the probe unit
// assumes the bench sets entry, tbl and dly before each probe is started
`timescale 1ns/1ps
module probe_far_side (
  // clock, reset and scenario set-up
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] dly,
  input wire logic [5:0] entry,
  input wire logic [7:0][15:0] tbl,
  // requests from the unit
  input wire logic cache_req,
  input wire logic [3:0] cache_fc,
  input wire logic walk_req,
  input wire logic [2:0] walk_level,
  // cache answer
  output logic cache_ack,
  output logic cache_hit,
  output logic cache_bus_fault_marker,
  output logic cache_wp,
  output logic cache_m,
  output logic cache_g,
  output logic cache_shared,
  // descriptor answer
  output logic desc_ack,
  output logic desc_bus_fault_marker,
  output logic [1:0] desc_type,
  output logic desc_long,
  output logic desc_limit,
  output logic desc_super,
  output logic [2:0] desc_ral,
  output logic [2:0] desc_wal,
  output logic desc_wp,
  output logic desc_m,
  output logic desc_g,
  output logic desc_shared,
  output logic [31:0] desc_addr,
  // observation for the bench
  output logic [3:0] seen_fc,
  output logic [3:0] fetches
);
  logic [2:0] cnt;
  logic [15:0] d;

  // ----------------------------------------------------------------
  // answer timing
  // ----------------------------------------------------------------
  // one-cycle ack after dly waiting cycles; fetches counts descriptors read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 3'h0;
      cache_ack <= 1'b0;
      desc_ack <= 1'b0;
      seen_fc <= 4'h0;
      fetches <= 4'h0;
    end else begin
      cache_ack <= cache_req && !cache_ack && cnt >= dly;
      desc_ack <= walk_req && !desc_ack && cnt >= dly;
      cnt <= ((cache_req || walk_req) && !cache_ack && !desc_ack) ? cnt + 3'h1 : 3'h0;
      if (cache_req) seen_fc <= cache_fc;
      if (walk_req && !desc_ack && cnt >= dly) fetches <= fetches + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // answer fields
  // ----------------------------------------------------------------
  // fields mean nothing without ack, so they show the inverse meanwhile
  assign d = desc_ack ? tbl[walk_level] : ~tbl[walk_level];
  assign {desc_type, desc_long, desc_limit, desc_super, desc_ral, desc_wal} = d[15:5];
  assign {desc_wp, desc_m, desc_g, desc_shared, desc_bus_fault_marker} = d[4:0];
  assign desc_addr = desc_ack ? {26'h10, walk_level, 3'h0} : ~{26'h10, walk_level, 3'h0};
  assign {cache_hit, cache_bus_fault_marker, cache_wp, cache_m, cache_g, cache_shared} =
    cache_ack ? entry : ~entry;
endmodule

// >>> testbench.sv
// self-checking bench: bus master, far-side model, condition-set and probe cases
// assumes ce high throughout and hreadyout fed back as hready
`timescale 1ns/1ps
module testbench import pmmu_probe_pkg::*;;
  logic hclk, hresetn, ce, hsel, hwrite, hresp, hreadyout, hready;
  logic [31:0] haddr, hwdata, hrdata, cache_laddr, desc_addr, v, r, st;
  logic [1:0] htrans, desc_type;
  logic [2:0] hsize, walk_level, desc_ral, desc_wal, dly;
  logic cache_req, cache_ack, cache_hit, cache_bus_fault_marker, cache_wp, cache_m, cache_g;
  logic cache_shared, walk_req, desc_ack, desc_bus_fault_marker, desc_long, desc_limit, desc_super;
  logic desc_wp, desc_m, desc_g, desc_shared;
  logic [3:0] cache_fc, seen_fc, fetches, f0;
  logic [5:0] entry;
  logic [7:0][15:0] tbl;
  logic [15:0] seed, s;
  logic [4:0] fcs[4] = '{5'h1b, 5'h0b, 5'h00, 5'h01};
  logic [3:0] efc[4] = '{4'hb, 4'h9, 4'h2, 4'h5};
  int bad_count, comparisons;

  assign hready = hreadyout;
  mmu_probe_and_condition_set dut (.*);
  probe_far_side far (.*);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // wait for hready at a rising edge, bounded
  task automatic hold();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      stop_test();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= hsize_word;
    hold();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hold();
    rd = hrdata;
  endtask

  // issue a command, poll for done, fetch status
  task automatic run(input logic [31:0] cmd, output logic [31:0] rs, output logic [31:0] sr);
    int n;
    bus(1'b1, off_cmd, cmd, rs);
    n = 0;
    do begin
      bus(1'b0, off_result, 32'h0, rs);
      n++;
    end while (rs[res_done] !== 1'b1 && n < 30);
    if (n >= 30) begin
      bad_count++;
      stop_test();
    end
    bus(1'b0, off_status, 32'h0, sr);
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [7:0] cexp(input logic [15:0] f, input logic [5:0] c);
    int p[8];
    p = '{sb_b, sb_l, sb_s, sb_a, sb_w, sb_i, sb_g, sb_c};
    return (f[p[c[3:1]]] ^ c[0]) ? 8'hff : 8'h00;
  endfunction

  // status after a level-zero lookup
  function automatic logic [15:0] kexp(input logic [5:0] e);
    if (!e[5]) return 16'h0200;
    return {e[4], 4'h0, e[3], e[4], 1'b0, e[2], 1'b0, e[1], e[0], 4'h0};
  endfunction

  function automatic logic [31:0] pc(input logic [2:0] l, input logic w, input logic [3:0] a,
                                     input logic [4:0] f, input logic sup);
    return {3'h0, l, w, a, f, 6'h0, sup, 1'b1, 8'h0};
  endfunction

  function automatic logic [31:0] da(input logic [2:0] l);
    return {26'h10, l, 3'h0};
  endfunction

  // one table walk: descriptors, status mask and value, fetch count, address
  task automatic walk(input logic [7:0] c, input logic [31:0] cmd, input logic [47:0] t,
                      input logic [15:0] m, input logic [15:0] x, input logic [3:0] nf,
                      input logic [31:0] ea);
    seed = lfsr(seed);
    dly <= seed[2:0];
    tbl <= {{5{16'h4010}}, t};
    bus(1'b1, off_ctrl, {24'h0, c}, v);
    f0 = fetches;
    run(cmd, r, st);
    chk(st & {16'h0, m}, {16'h0, x});
    chk({28'h0, fetches - f0}, {28'h0, nf});
    chk({28'h0, r[res_ret], r[17:15]}, {28'h0, cmd[24:21]});
    bus(1'b0, off_daddr, 32'h0, v);
    if (cmd[24]) chk(v, ea);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = hsize_word;
    hwdata = 32'h0;
    dly = 3'h0;
    entry = 6'h0;
    tbl = '0;
    seed = 16'h005f;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, address register readback and unmapped places
    bus(1'b0, off_ctrl, 32'h0, v);
    chk(v, {24'h0, ctrl_reset});
    bus(1'b0, off_status, 32'h0, v);
    chk(v, {16'h0, status_reset});
    bus(1'b1, 8'h40, 32'hffff_ffff, v);
    bus(1'b0, 8'h40, 32'h0, v);
    chk(v, 32'h0);
    bus(1'b1, off_laddr, {seed, seed}, v);
    bus(1'b0, off_laddr, 32'h0, v);
    chk(v, {seed, seed});
    chk(cache_laddr, {seed, seed});
    chk({31'h0, hresp}, 32'h0);
    // condition-set over every valid code against random status
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      s = seed & 16'heeb7;
      bus(1'b1, off_status, {16'h0, s}, v);
      bus(1'b0, off_status, 32'h0, v);
      chk(v, {16'h0, s});
      for (int c = 0; c < 16; c++) begin
        run({10'h0, 6'(c), 8'h02, 8'h03}, r, st);
        chk({24'h0, r[7:0]}, {24'h0, cexp(s, 6'(c))});
        chk(st, {16'h0, s});
      end
    end
    run({10'h0, 6'h2a, 8'h02, 8'h03}, r, st);
    chk({23'h0, r[res_cbad], r[7:0]}, 32'h100);
    // every destination mode
    for (int d = 0; d < 64; d++) begin
      run({16'h0007, 8'h02, 2'h0, 6'(d)}, r, st);
      chk({31'h0, r[res_ea_rej]}, {31'h0, d[5:3] == 3'h1 || (d[5:3] == 3'h7 && d[2:0] > 3'h1)});
    end
    // probe refusals
    bus(1'b1, off_ctrl, 32'h0, v);
    run(pc(3'h0, 1'b1, 4'h0, 5'h15, 1'b1), r, st);
    chk({23'h0, r[res_illop], r[31:24]}, {23'h0, 1'b1, vec_illegal});
    bus(1'b1, off_ctrl, 32'h35, v);
    run(pc(3'h0, 1'b1, 4'h0, 5'h15, 1'b0), r, st);
    chk({31'h0, r[res_priv]}, 32'h1);
    for (int a = 1; a < 16; a += 7) begin
      run(pc(3'h0, 1'b1, 4'(a), 5'h15, 1'b1), r, st);
      chk({31'h0, r[res_fline]}, 32'h1);
    end
    run(pc(3'h1, 1'b1, 4'h0, 5'h03, 1'b1), r, st);
    chk({31'h0, r[res_fline]}, 32'h1);
    // level-zero lookups through each function-code source
    bus(1'b1, off_operand, 32'h0529, v);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      entry <= seed[5:0];
      dly <= seed[9:7];
      f0 = fetches;
      run(pc(3'h0, 1'b1, 4'h0, fcs[i % 4], 1'b1), r, st);
      chk({28'h0, seen_fc}, {28'h0, efc[i % 4]});
      chk(st, {16'h0, kexp(seed[5:0])});
      chk({28'h0, fetches - f0}, 32'h0);
    end
    // table walks: full depth, limit stop, bus error, page root
    walk(8'h35, pc(3'h3, 1'b0, 4'hd, 5'h11, 1'b1), {16'h400e, 16'h8010, 16'hab20},
         16'hffff, 16'h2cb3, 4'h3, da(3'h2));
    walk(8'h35, pc(3'h7, 1'b1, 4'h0, 5'h15, 1'b1), {16'h4010, 16'hb700, 16'hc800},
         16'hffff, 16'h4602, 4'h2, 32'h0);
    walk(8'h35, pc(3'h3, 1'b0, 4'h8, 5'h1f, 1'b1), {16'h4010, 16'h8001, 16'h8000},
         16'h8200, 16'h8200, 4'h2, da(3'h0));
    walk(8'h33, pc(3'h2, 1'b1, 4'ha, 5'h10, 1'b1), {3{16'h8000}},
         16'h0207, 16'h0000, 4'h0, 32'h0);
    stop_test();
  end
endmodule
